/* rtl/cdc_pkg.sv */
package cdc_pkg;

  // Register offsets on the control port
  localparam logic [7:0] SEC_BITCLK_DIV_LOW_ADDR  = 8'h3D;
  localparam logic [7:0] ANALOG_NM_DIV_CFG_ADDR   = 8'h3E;
  localparam logic [7:0] CORE_DIV_ENABLES_ADDR    = 8'h44;
  localparam logic [7:0] PORT_DIV_ENABLES_ADDR    = 8'h45;
  localparam logic [7:0] CLKOUT_SRC_SELECT_ADDR   = 8'h46;

  // Reset values
  localparam logic [7:0] SEC_BITCLK_DIV_LOW_RST   = 8'h01;
  localparam logic [5:0] ANALOG_NM_RATIO_RST      = 6'h01;
  localparam logic [2:0] CORE_DIV_ENABLES_RST     = 3'h0;
  localparam logic [7:0] PORT_DIV_ENABLES_RST     = 8'h00;
  localparam logic [2:0] CLKOUT_SRC_RST           = 3'h0;

  // Field positions
  localparam int N_RATIO_ENABLE_BIT               = 2;
  localparam int M_RATIO_ENABLE_BIT               = 1;
  localparam int PDM_MIC_DIV_ENABLE_BIT           = 0;
  localparam int ADC_MOD_DIV_ENABLE_BIT           = 6;
  localparam int DAC_MOD_DIV_ENABLE_BIT           = 4;
  localparam int PRI_BITCLK_DIV_ENABLE_BIT        = 3;
  localparam int SEC_BITCLK_DIV_ENABLE_BIT        = 2;
  localparam int PRI_FRAMESYNC_DIV_ENABLE_BIT     = 1;
  localparam int SEC_FRAMESYNC_DIV_ENABLE_BIT     = 0;
  localparam int ANALOG_NM_RATIO_MSB              = 5;
  localparam int CLKOUT_SRC_MSB                   = 2;

  // Ratio codes of zero stand for the full range
  localparam logic [9:0] SEC_BITCLK_ZERO_RATIO    = 10'h200;
  localparam logic [6:0] ANALOG_NM_ZERO_RATIO     = 7'h40;
  // Ratio used for every divider when automatic detection owns the tree
  localparam logic [9:0] AUTO_RATIO_DEFAULT       = 10'h001;

  typedef enum logic [2:0] {
    CDC_SRC_PLL,
    CDC_SRC_PRI_BITCLK,
    CDC_SRC_SEC_BITCLK,
    CDC_SRC_CONTROL_CLK,
    CDC_SRC_OSC,
    CDC_SRC_DSP
  } cdc_clkout_src_type;

  typedef struct packed {
    logic adc_modulator_div_enable;
    logic dac_modulator_div_enable;
    logic pri_port_bitclk_div_enable;
    logic sec_port_bitclk_div_enable;
    logic pri_port_framesync_div_enable;
    logic sec_port_framesync_div_enable;
    logic n_ratio_enable;
    logic m_ratio_enable;
    logic pdm_mic_div_enable;
  } cdc_enables_type;

  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cdc_reg_req_type;

endpackage

/* rtl/cdc_ratio_div.sv */
`timescale 1ns/1ps
// Divides a source tick train by a ratio; held idle while disabled
module cdc_ratio_div (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  // Control
  input  wire logic       i_enable,
  input  wire logic [9:0] i_ratio,
  input  wire logic       i_src_tick,
  // Output
  output logic            o_tick
);

  logic [9:0] count;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n || !i_enable) begin
      count  <= 10'h000;
      o_tick <= 1'b0;
    end else if (i_src_tick) begin
      if (count + 10'h001 >= i_ratio) begin
        count  <= 10'h000;
        o_tick <= 1'b1;
      end else begin
        count  <= count + 10'h001;
        o_tick <= 1'b0;
      end
    end else begin
      o_tick <= 1'b0;
    end
  end

endmodule // cdc_ratio_div

/* rtl/cdc_clock_ctrl.sv */
`timescale 1ns/1ps
module cdc_clock_ctrl (
  // Clock and reset
  input  wire logic                        i_clk,
  input  wire logic                        i_rst_n,
  // Control port register access
  input  wire cdc_pkg::cdc_reg_req_type    i_req,
  output logic [7:0]                       o_rdata,
  // Neighbouring configuration
  input  wire logic                        i_auto_detect_en,
  input  wire logic                        i_sec_port_bitclk_div_high,
  // Source clock ticks
  input  wire logic                        i_src_pll_tick,
  input  wire logic                        i_src_pri_bitclk_tick,
  input  wire logic                        i_src_sec_bitclk_tick,
  input  wire logic                        i_src_control_tick,
  input  wire logic                        i_src_osc_tick,
  input  wire logic                        i_src_dsp_tick,
  // Divider outputs
  output logic                             o_sec_port_bitclk_tick,
  output logic                             o_analog_nm_tick,
  output logic                             o_clkout_src_tick,
  output cdc_pkg::cdc_enables_type         o_enables,
  output logic [9:0]                       o_sec_port_bitclk_ratio,
  output logic [6:0]                       o_analog_nm_ratio_eff
);

  logic [7:0]                  sec_port_bitclk_div_low;
  logic [5:0]                  analog_nm_ratio;
  logic [2:0]                  core_enables;
  logic [7:0]                  port_enables;
  logic [2:0]                  clock_output_source;
  logic [8:0]                  sec_code;
  logic [9:0]                  next_sec_ratio;
  logic [6:0]                  next_nm_ratio;
  logic                        clkout_src_tick;
  logic                        wr_sec_low;
  logic                        wr_nm_cfg;
  logic                        wr_core_en;
  logic                        wr_port_en;
  logic                        wr_clkout_sel;
  cdc_pkg::cdc_clkout_src_type clkout_src_sel;

  // Write strobes; unmapped offsets match none and are dropped
  assign wr_sec_low    = i_req.wr && (i_req.addr == cdc_pkg::SEC_BITCLK_DIV_LOW_ADDR);
  assign wr_nm_cfg     = i_req.wr && (i_req.addr == cdc_pkg::ANALOG_NM_DIV_CFG_ADDR);
  assign wr_core_en    = i_req.wr && (i_req.addr == cdc_pkg::CORE_DIV_ENABLES_ADDR);
  assign wr_port_en    = i_req.wr && (i_req.addr == cdc_pkg::PORT_DIV_ENABLES_ADDR);
  assign wr_clkout_sel = i_req.wr && (i_req.addr == cdc_pkg::CLKOUT_SRC_SELECT_ADDR);

  // Secondary bit-clock ratio low byte
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      sec_port_bitclk_div_low <= cdc_pkg::SEC_BITCLK_DIV_LOW_RST;
    end else if (wr_sec_low) begin
      sec_port_bitclk_div_low <= i_req.wdata;
    end
  end

  // Analog N-M ratio, upper bits read-only
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      analog_nm_ratio <= cdc_pkg::ANALOG_NM_RATIO_RST;
    end else if (wr_nm_cfg) begin
      analog_nm_ratio <= i_req.wdata[cdc_pkg::ANALOG_NM_RATIO_MSB:0];
    end
  end

  // Core divider enables
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      core_enables <= cdc_pkg::CORE_DIV_ENABLES_RST;
    end else if (wr_core_en) begin
      core_enables <= i_req.wdata[cdc_pkg::N_RATIO_ENABLE_BIT:0];
    end
  end

  // Port divider enables
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      port_enables <= cdc_pkg::PORT_DIV_ENABLES_RST;
    end else if (wr_port_en) begin
      // Reserved bits 7 and 5 are read/write; software keeps them zero
      port_enables <= i_req.wdata;
    end
  end

  // Clock output source code
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      clock_output_source <= cdc_pkg::CLKOUT_SRC_RST;
    end else if (wr_clkout_sel) begin
      clock_output_source <= i_req.wdata[cdc_pkg::CLKOUT_SRC_MSB:0];
    end
  end

  // Read data, read-only reserved bits return zero
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_rdata <= 8'h00;
    end else begin
      unique case (i_req.addr)
        cdc_pkg::SEC_BITCLK_DIV_LOW_ADDR: o_rdata <= sec_port_bitclk_div_low;
        cdc_pkg::ANALOG_NM_DIV_CFG_ADDR:  o_rdata <= {2'h0, analog_nm_ratio};
        cdc_pkg::CORE_DIV_ENABLES_ADDR:   o_rdata <= {5'h00, core_enables};
        cdc_pkg::PORT_DIV_ENABLES_ADDR:   o_rdata <= port_enables;
        cdc_pkg::CLKOUT_SRC_SELECT_ADDR:  o_rdata <= {5'h00, clock_output_source};
        default:                          o_rdata <= 8'h00;
      endcase
    end
  end

  // Ratio decode
  always_comb begin
    sec_code = {i_sec_port_bitclk_div_high, sec_port_bitclk_div_low};
    if (i_auto_detect_en) begin
      next_sec_ratio = cdc_pkg::AUTO_RATIO_DEFAULT;
      next_nm_ratio  = cdc_pkg::AUTO_RATIO_DEFAULT[6:0];
    end else begin
      // Zero code divides by the full range of the field
      next_sec_ratio = (sec_code == 9'h000) ? cdc_pkg::SEC_BITCLK_ZERO_RATIO
                                            : {1'b0, sec_code};
      next_nm_ratio  = (analog_nm_ratio == 6'h00) ? cdc_pkg::ANALOG_NM_ZERO_RATIO
                                                  : {1'b0, analog_nm_ratio};
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_sec_port_bitclk_ratio <= 10'h001;
      o_analog_nm_ratio_eff   <= 7'h01;
    end else begin
      o_sec_port_bitclk_ratio <= next_sec_ratio;
      o_analog_nm_ratio_eff   <= next_nm_ratio;
    end
  end

  // Enable fan-out
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_enables <= '0;
    end else begin
      o_enables.n_ratio_enable                <= core_enables[cdc_pkg::N_RATIO_ENABLE_BIT];
      o_enables.m_ratio_enable                <= core_enables[cdc_pkg::M_RATIO_ENABLE_BIT];
      o_enables.pdm_mic_div_enable            <= core_enables[cdc_pkg::PDM_MIC_DIV_ENABLE_BIT];
      o_enables.adc_modulator_div_enable      <= port_enables[cdc_pkg::ADC_MOD_DIV_ENABLE_BIT];
      o_enables.dac_modulator_div_enable      <= port_enables[cdc_pkg::DAC_MOD_DIV_ENABLE_BIT];
      o_enables.pri_port_bitclk_div_enable    <= port_enables[cdc_pkg::PRI_BITCLK_DIV_ENABLE_BIT];
      o_enables.sec_port_bitclk_div_enable    <= port_enables[cdc_pkg::SEC_BITCLK_DIV_ENABLE_BIT];
      o_enables.pri_port_framesync_div_enable <= port_enables[cdc_pkg::PRI_FRAMESYNC_DIV_ENABLE_BIT];
      o_enables.sec_port_framesync_div_enable <= port_enables[cdc_pkg::SEC_FRAMESYNC_DIV_ENABLE_BIT];
    end
  end

  // Codes 6 and 7 have no enum member and land in the default
  assign clkout_src_sel = cdc_pkg::cdc_clkout_src_type'(clock_output_source);

  // Clock output source mux; reserved codes give no ticks
  always_comb begin
    unique case (clkout_src_sel)
      cdc_pkg::CDC_SRC_PLL:         clkout_src_tick = i_src_pll_tick;
      cdc_pkg::CDC_SRC_PRI_BITCLK:  clkout_src_tick = i_src_pri_bitclk_tick;
      cdc_pkg::CDC_SRC_SEC_BITCLK:  clkout_src_tick = i_src_sec_bitclk_tick;
      cdc_pkg::CDC_SRC_CONTROL_CLK: clkout_src_tick = i_src_control_tick;
      cdc_pkg::CDC_SRC_OSC:         clkout_src_tick = i_src_osc_tick;
      cdc_pkg::CDC_SRC_DSP:         clkout_src_tick = i_src_dsp_tick;
      default:                      clkout_src_tick = 1'b0;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_clkout_src_tick <= 1'b0;
    end else begin
      o_clkout_src_tick <= clkout_src_tick;
    end
  end

  // Dividers run from registered ratios so a mid-count write cannot glitch
  cdc_ratio_div u_sec_bitclk_div (
    .i_clk      (i_clk),
    .i_rst_n    (i_rst_n),
    .i_enable   (o_enables.sec_port_bitclk_div_enable),
    .i_ratio    (o_sec_port_bitclk_ratio),
    .i_src_tick (i_src_pll_tick),
    .o_tick     (o_sec_port_bitclk_tick)
  );

  cdc_ratio_div u_analog_nm_div (
    .i_clk      (i_clk),
    .i_rst_n    (i_rst_n),
    .i_enable   (o_enables.n_ratio_enable & o_enables.m_ratio_enable),
    .i_ratio    ({3'h0, o_analog_nm_ratio_eff}),
    .i_src_tick (i_src_pll_tick),
    .o_tick     (o_analog_nm_tick)
  );

endmodule // cdc_clock_ctrl

/* verif/cdc_clock_ctrl_properties.sv */
`timescale 1ns/1ps
module cdc_clock_ctrl_properties (
  // Clock and reset
  input wire logic                     i_clk,
  input wire logic                     i_rst_n,
  // Register access
  input wire cdc_pkg::cdc_reg_req_type i_req,
  input wire logic [7:0]               o_rdata,
  input wire logic                     i_auto_detect_en,
  input wire logic                     i_sec_port_bitclk_div_high,
  // Divider outputs
  input wire logic                     o_sec_port_bitclk_tick,
  input wire logic                     o_analog_nm_tick,
  input wire cdc_pkg::cdc_enables_type o_enables,
  input wire logic [9:0]               o_sec_port_bitclk_ratio,
  input wire logic [6:0]               o_analog_nm_ratio_eff
);
  default clocking dclk @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  a_port_enables: assert property (
    i_req.wr && i_req.addr == 8'h45 ##1 !(i_req.wr && i_req.addr == 8'h45) |=> o_enables[8:3] ==
    {$past(i_req.wdata[6], 2), $past(i_req.wdata[4], 2), $past(i_req.wdata[3:0], 2)})
    else $error("port divider enables wrong");
  a_core_enables: assert property (
    i_req.wr && i_req.addr == 8'h44 ##1 !(i_req.wr && i_req.addr == 8'h44) |=>
    o_enables[2:0] == $past(i_req.wdata[2:0], 2))
    else $error("core divider enables wrong");
  // Read data and ratio are both one edge behind the same register
  a_sec_ratio: assert property (
    $past(i_rst_n) && $past(i_req.addr) == 8'h3D && !$past(i_auto_detect_en) |->
    o_sec_port_bitclk_ratio == (({$past(i_sec_port_bitclk_div_high), o_rdata} == 9'h000) ? 10'h200 :
    {1'b0, $past(i_sec_port_bitclk_div_high), o_rdata}))
    else $error("secondary bit clock ratio wrong");
  a_nm_ratio: assert property (
    $past(i_rst_n) && $past(i_req.addr) == 8'h3E && !$past(i_auto_detect_en) |-> o_rdata[7:6] == 2'h0 &&
    o_analog_nm_ratio_eff == ((o_rdata[5:0] == 6'h00) ? 7'h40 : {1'b0, o_rdata[5:0]}))
    else $error("analog ratio wrong");
  a_auto_ratio: assert property (
    $past(i_rst_n) && $past(i_auto_detect_en) |->
    o_sec_port_bitclk_ratio == 10'h001 && o_analog_nm_ratio_eff == 7'h01)
    else $error("auto detect ratio wrong");
  a_reset_values: assert property (
    !$past(i_rst_n) |-> o_enables == '0 && o_rdata == 8'h00 &&
    o_sec_port_bitclk_ratio == 10'h001 && o_analog_nm_ratio_eff == 7'h01)
    else $error("reset values wrong");
  a_sec_gated: assert property (
    !o_enables.sec_port_bitclk_div_enable [*3] |-> !o_sec_port_bitclk_tick)
    else $error("disabled bit clock divider ticked");
  a_nm_gated: assert property (
    !(o_enables.n_ratio_enable && o_enables.m_ratio_enable) [*3] |-> !o_analog_nm_tick)
    else $error("disabled analog divider ticked");

  c_port_write: cover property (i_req.wr && i_req.addr == 8'h45);
  c_auto: cover property (i_auto_detect_en && o_sec_port_bitclk_ratio == 10'h001);
  c_sec_tick: cover property (o_sec_port_bitclk_tick);
  c_nm_tick: cover property (o_analog_nm_tick);
endmodule // cdc_clock_ctrl_properties

bind cdc_clock_ctrl cdc_clock_ctrl_properties chk_u (
  .i_clk, .i_rst_n, .i_req, .o_rdata, .i_auto_detect_en, .i_sec_port_bitclk_div_high,
  .o_sec_port_bitclk_tick, .o_analog_nm_tick, .o_enables, .o_sec_port_bitclk_ratio, .o_analog_nm_ratio_eff
);

/* verif/cdc_clock_ctrl_tb.sv */
`timescale 1ns/1ps
module cdc_clock_ctrl_tb;
  logic                     i_clk;
  logic                     i_rst_n;
  logic                     i_auto_detect_en;
  logic                     i_sec_port_bitclk_div_high;
  logic [5:0]               src;
  cdc_pkg::cdc_reg_req_type i_req;
  cdc_pkg::cdc_enables_type o_enables;
  logic [7:0]               o_rdata;
  wire logic [2:0]          o_tick;
  logic [9:0]               o_sec_ratio;
  logic [6:0]               o_nm_ratio;
  logic [7:0]               lo;
  logic [7:0]               corner [4];
  logic [31:0]              seed;
  int                       mem [int];
  int                       bad_count;
  int                       checks_done;

  cdc_clock_ctrl dut_u (
    .i_clk, .i_rst_n, .i_req, .o_rdata, .i_auto_detect_en, .i_sec_port_bitclk_div_high,
    .i_src_pll_tick(src[0]), .i_src_pri_bitclk_tick(src[1]), .i_src_sec_bitclk_tick(src[2]),
    .i_src_control_tick(src[3]), .i_src_osc_tick(src[4]), .i_src_dsp_tick(src[5]),
    .o_sec_port_bitclk_tick(o_tick[0]), .o_analog_nm_tick(o_tick[1]), .o_clkout_src_tick(o_tick[2]),
    .o_enables, .o_sec_port_bitclk_ratio(o_sec_ratio), .o_analog_nm_ratio_eff(o_nm_ratio)
  );

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Defined field bits only, so reserved positions keep their reset values
  function automatic int msk(int a);
    case (a)
      'h3D: return 'hFF;
      'h3E: return 'h3F;
      'h45: return 'h5F;
      default: return 'h07;
    endcase
  endfunction

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Strobe stays high across back-to-back writes; a read drops it
  task automatic wr(input int a, input logic [7:0] d);
    if (mem.exists(a)) begin
      d = d & 8'(msk(a));
      mem[a] = d;
    end
    i_req = '{1'b1, 8'(a), d};
    @(negedge i_clk);
  endtask

  task automatic rd(input int a);
    i_req = '{1'b0, 8'(a), 8'h00};
    @(negedge i_clk);
    chk("rdata", o_rdata, mem.exists(a) ? 16'(mem[a]) : 16'h0000);
  endtask

  task automatic outs();
    int s;
    int n;
    s = {i_sec_port_bitclk_div_high, mem['h3D][7:0]};
    n = mem['h3E];
    if (i_auto_detect_en) begin
      s = 1;
      n = 1;
    end else begin
      s = (s == 0) ? 512 : s;
      n = (n == 0) ? 64 : n;
    end
    chk("sec_ratio", o_sec_ratio, 16'(s));
    chk("nm_ratio", o_nm_ratio, 16'(n));
    chk("enables", o_enables, {mem['h45][6], mem['h45][4], mem['h45][3:0], mem['h44][2:0]});
  endtask

  // Four-state sums so an unknown tick poisons the count
  task automatic cnt(input int es, input int en);
    logic [15:0] s;
    logic [15:0] n;
    s = 16'h0000;
    n = 16'h0000;
    repeat (4) @(negedge i_clk);
    repeat (30) begin
      s = s + 16'(o_tick[0]);
      n = n + 16'(o_tick[1]);
      @(negedge i_clk);
    end
    chk("sec_ticks", s, 16'(es));
    chk("nm_ticks", n, 16'(en));
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  initial begin
    seed = 65636;
    bad_count = 0;
    checks_done = 0;
    corner = '{8'h00, 8'hFF, 8'hFF, 8'h00};
    i_rst_n = 1'b0;
    i_req = '0;
    i_auto_detect_en = 1'b0;
    i_sec_port_bitclk_div_high = 1'b0;
    src = 6'h00;
    mem = '{'h3D: 1, 'h3E: 1, 'h44: 0, 'h45: 0, 'h46: 0};
    repeat (3) @(negedge i_clk);
    i_rst_n = 1'b1;
    foreach (mem[a]) rd(a);
    outs();
    // First passes hit the zero and all-ones ratio codes
    for (int i = 0; i < 20; i++) begin
      lo = (i < 4) ? corner[i] : 8'(rnd());
      i_sec_port_bitclk_div_high = (i < 4) ? i[0] : lo[7];
      i_auto_detect_en = (i % 5 == 4);
      wr('h3D, lo);
      wr('h3E, lo);
      wr('h44, 8'(rnd()));
      wr('h45, 8'(rnd()));
      wr('h50 + i, 8'(rnd()));
      foreach (mem[a]) rd(a);
      rd('h50 + i);
      outs();
    end
    i_auto_detect_en = 1'b0;
    for (int c = 0; c < 8; c++) begin
      wr('h46, 8'(c));
      rd('h46);
      repeat (6) begin
        src = 6'(rnd());
        @(negedge i_clk);
        chk("clkout_tick", o_tick[2], (c < 6) ? src[c] : 1'b0);
      end
    end
    src = 6'h01;
    i_sec_port_bitclk_div_high = 1'b0;
    wr('h3D, 8'h03);
    wr('h3E, 8'h05);
    wr('h44, 8'h06);
    wr('h45, 8'h04);
    rd('h45);
    cnt(10, 6);
    wr('h44, 8'h02);
    wr('h45, 8'h00);
    rd('h44);
    cnt(0, 0);
    // Mid-run reset with programmed registers: all fall back
    i_rst_n = 1'b0;
    repeat (3) @(negedge i_clk);
    i_rst_n = 1'b1;
    mem = '{'h3D: 1, 'h3E: 1, 'h44: 0, 'h45: 0, 'h46: 0};
    foreach (mem[a]) rd(a);
    outs();
    cnt(0, 0);
    results();
  end
endmodule // cdc_clock_ctrl_tb
